// ===== design/csbo_pkg.sv
// Shared types and constants for the socket select and backoff glue.
package csbo_pkg;

    // Synchroniser depth for board straps and a safe post-reset level.
    localparam int   SYNC_STAGES    = 2;
    localparam logic SYNC_RESET_VAL = 1'b0;

    // Fixed drive level of the open-drain socket A disable pin.
    localparam logic OD_DRIVE_LEVEL = 1'b0;

    // Backoff sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_BACKOFF = 2'b01,
        ST_GRANT   = 2'b10
    } csbo_state_t;

    // Processor local bus cycle strobes, all active low.
    typedef struct packed {
        logic addr_strobe_n;
        logic ready_n;
        logic burst_last_n;
    } csbo_bus_t;

endpackage : csbo_pkg

// ===== design/csbo_sync.sv
// Two-stage level synchroniser for board strap inputs.
module csbo_sync #(
    parameter int   WIDTH     = 1,
    parameter logic RESET_VAL = 1'b0
) (
    // Clock, reset and freeze.
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    // Raw level and its synchronised copy.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // The second stage reads the first; both stages hold while the clock enable is low.
    always_comb begin
        meta_d = clk_en ? async_in : meta_q;
        sync_d = clk_en ? meta_q : sync_q;
    end

    // Both stages reset to a constant.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= {WIDTH{RESET_VAL}};
            sync_q <= {WIDTH{RESET_VAL}};
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : csbo_sync

// ===== design/csbo_top.sv
// Socket select gating and processor backoff sequencer for the local bus.
// What this block does
// - Socket B enabled disables socket A latch.
// - Processor hold grant disables socket A latch.
// - Latch enable is unregistered OR of both.
// - Never drive socket A disable pin high.
// - Open-drain low when socket B enabled.
// - Exactly one processor socket enabled.
// - Bridge backoff request asserts processor backoff.
// - Backoff only during a processor bus access.
// - Backoff only when socket B is enabled.
// - Backoff also needs bridge hold request.
// - Hold grant follows backoff one clock later.
// - Block, not processor, supplies bridge hold grant.
// - Backoff held until bridge drops hold request.
// - Ready acknowledges; ready with burst-last ends.
module csbo_top (
    // Clock, reset and freeze.
    input  wire logic               REF_CLK,
    input  wire logic               RESET_N,
    input  wire logic               CLK_EN,
    // Processor local bus.
    input  wire csbo_pkg::csbo_bus_t LOCAL_BUS,
    input  wire logic               CPU_HOLD_GRANT,
    // Socket select strap and socket A open-drain pin.
    input  wire logic               SOCKET_B_EMUL_DISABLE_N,
    input  wire logic               SOCKET_A_EMUL_DISABLE_N_I,
    output logic                    SOCKET_A_EMUL_DISABLE_N_O,
    output logic                    SOCKET_A_EMUL_DISABLE_N_OE,
    // Socket A address latch.
    output logic                    ADDR_LATCH_OUT_EN_N,
    // Bridge handshake.
    input  wire logic               BRIDGE_BACKOFF_REQUEST,
    input  wire logic               BRIDGE_HOLD_REQUEST,
    output logic                    BRIDGE_HOLD_GRANT,
    // Processor backoff.
    output logic                    CPU_BACKOFF_N
);
    import csbo_pkg::*;

    csbo_state_t state_q;
    csbo_state_t state_d;
    logic        busy_q;
    logic        busy_d;
    logic        busy_now;
    logic        socket_b_on;
    logic        qualify;
    logic        backoff_n_q;
    logic        backoff_n_d;
    logic        grant_q;
    logic        grant_d;

    // An access ends when ready and burst-last coincide.
    function automatic logic access_ends(input csbo_bus_t b);
        return !b.ready_n && !b.burst_last_n;
    endfunction : access_ends

    // The strap is asynchronous to the bus clock, so the sequencer only
    // sees it after two stages; it resets low so no backoff is possible
    // until the strap has really been sampled.
    csbo_sync #(
        .WIDTH     (1),
        .RESET_VAL (SYNC_RESET_VAL)
    ) u_strap_sync (
        .clk      (REF_CLK),
        .reset_n  (RESET_N),
        .clk_en   (CLK_EN),
        .async_in (SOCKET_B_EMUL_DISABLE_N),
        .sync_out (socket_b_on)
    );

    // Pure gates: the latch enable must follow the strap and the hold grant,
    // and the open-drain pin the strap alone, without a clock of delay, so
    // they are not registered even though other outputs are.
    assign ADDR_LATCH_OUT_EN_N =
        SOCKET_B_EMUL_DISABLE_N | CPU_HOLD_GRANT;
    assign SOCKET_A_EMUL_DISABLE_N_O  = OD_DRIVE_LEVEL;
    assign SOCKET_A_EMUL_DISABLE_N_OE = SOCKET_B_EMUL_DISABLE_N;

    // Bus access tracking: opens on address strobe, closes on last ready.
    always_comb begin
        busy_now = busy_q || !LOCAL_BUS.addr_strobe_n;
        busy_d   = busy_now && !access_ends(LOCAL_BUS);
    end

    // Backoff qualifiers, all sampled on the same edge.
    assign qualify = BRIDGE_BACKOFF_REQUEST && busy_now
                     && socket_b_on && BRIDGE_HOLD_REQUEST;

    // Sequencer next state; backoff persists after the bridge drops its
    // backoff request, because that happens as soon as it is granted.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (qualify) begin
                    state_d = ST_BACKOFF;
                end
            end
            ST_BACKOFF: begin
                state_d = BRIDGE_HOLD_REQUEST ? ST_GRANT : ST_IDLE;
            end
            ST_GRANT: begin
                if (!BRIDGE_HOLD_REQUEST) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        backoff_n_d = (state_d == ST_IDLE);
        grant_d     = (state_d == ST_GRANT);
    end

    // Registers; everything freezes while the clock enable is low.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q     <= ST_IDLE;
            busy_q      <= 1'b0;
            backoff_n_q <= 1'b1;
            grant_q     <= 1'b0;
        end else if (CLK_EN) begin
            state_q     <= state_d;
            busy_q      <= busy_d;
            backoff_n_q <= backoff_n_d;
            grant_q     <= grant_d;
        end
    end

    assign CPU_BACKOFF_N     = backoff_n_q;
    assign BRIDGE_HOLD_GRANT = grant_q;

    // Checks on the gates.
    latch_b_on_off_a: assert property (@(posedge REF_CLK)
        SOCKET_B_EMUL_DISABLE_N |-> ADDR_LATCH_OUT_EN_N)
        else $error("Latch enabled while socket B active.");
    latch_hold_off_a: assert property (@(posedge REF_CLK)
        CPU_HOLD_GRANT |-> ADDR_LATCH_OUT_EN_N)
        else $error("Latch enabled while bus granted away.");
    latch_or_a: assert property (@(posedge REF_CLK)
        (!SOCKET_B_EMUL_DISABLE_N && !CPU_HOLD_GRANT)
            |-> !ADDR_LATCH_OUT_EN_N)
        else $error("Latch disabled with no cause.");
    od_low_only_a: assert property (@(posedge REF_CLK)
        SOCKET_A_EMUL_DISABLE_N_OE |-> !SOCKET_A_EMUL_DISABLE_N_O)
        else $error("Socket A pin driven high.");
    od_enable_a: assert property (@(posedge REF_CLK)
        SOCKET_A_EMUL_DISABLE_N_OE == SOCKET_B_EMUL_DISABLE_N)
        else $error("Socket A pin drive mismatches strap.");
    one_socket_a: assert property (@(posedge REF_CLK)
        (SOCKET_A_EMUL_DISABLE_N_OE && !SOCKET_A_EMUL_DISABLE_N_O)
            == SOCKET_B_EMUL_DISABLE_N)
        else $error("Both or neither processor socket enabled.");

    // Checks on the sequencer.
    bus_backoff_n_cause_a: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        $fell(CPU_BACKOFF_N) |-> $past(busy_now) && $past(socket_b_on)
                                 && $past(BRIDGE_HOLD_REQUEST))
        else $error("Backoff asserted without qualifiers.");
    grant_delay_a: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        (state_q == ST_BACKOFF && CLK_EN && BRIDGE_HOLD_REQUEST)
            |=> BRIDGE_HOLD_GRANT && !CPU_BACKOFF_N)
        else $error("Hold grant not one clock after backoff.");
    grant_needs_bus_backoff_n_a: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        $rose(BRIDGE_HOLD_GRANT) |-> !$past(CPU_BACKOFF_N))
        else $error("Hold grant without prior backoff.");
    bus_backoff_n_hold_a: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        (!CPU_BACKOFF_N && BRIDGE_HOLD_REQUEST) |=> !CPU_BACKOFF_N)
        else $error("Backoff dropped while hold requested.");
    bus_backoff_n_release_a: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        (!CPU_BACKOFF_N && !BRIDGE_HOLD_REQUEST && CLK_EN)
            |=> CPU_BACKOFF_N && !BRIDGE_HOLD_GRANT)
        else $error("Backoff not released after hold drop.");
    reset_idle_a: assert property (@(posedge REF_CLK)
        $rose(RESET_N) |-> CPU_BACKOFF_N && !BRIDGE_HOLD_GRANT)
        else $error("Backoff or grant active out of reset.");

    // Further sequencer checks. The freeze check matters because the clock
    // enable also stalls the strap synchroniser, so a frozen sequencer must
    // neither start nor end a backoff on its own.
    bus_backoff_n_request_a: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        $fell(CPU_BACKOFF_N) |-> $past(BRIDGE_BACKOFF_REQUEST))
        else $error("Backoff asserted without a bridge request.");
    strap_gate_a: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        (!socket_b_on && CPU_BACKOFF_N) |=> CPU_BACKOFF_N)
        else $error("Backoff started with socket B disabled.");
    hold_gate_a: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        (!BRIDGE_HOLD_REQUEST && CPU_BACKOFF_N) |=> CPU_BACKOFF_N)
        else $error("Backoff started without a hold request.");
    grant_only_bus_backoff_n_a: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        BRIDGE_HOLD_GRANT |-> !CPU_BACKOFF_N)
        else $error("Hold grant given while processor not backed off.");
    access_close_a: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        (CLK_EN && access_ends(LOCAL_BUS)) |=> !busy_q)
        else $error("Access still open after ready with burst-last.");
    freeze_hold_a: assert property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        !CLK_EN |=> $stable(CPU_BACKOFF_N) && $stable(BRIDGE_HOLD_GRANT))
        else $error("Sequencer outputs moved while frozen.");

    // Main scenarios.
    bus_backoff_n_seen_c: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
        $fell(CPU_BACKOFF_N) ##1 BRIDGE_HOLD_GRANT);
    release_seen_c: cover property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        BRIDGE_HOLD_GRANT ##1 CPU_BACKOFF_N);
    socket_a_live_c: cover property (@(posedge REF_CLK)
        !SOCKET_A_EMUL_DISABLE_N_OE && SOCKET_A_EMUL_DISABLE_N_I
        && !ADDR_LATCH_OUT_EN_N);
    freeze_seen_c: cover property (@(posedge REF_CLK)
        disable iff (!RESET_N)
        !CLK_EN && BRIDGE_HOLD_GRANT);

endmodule : csbo_top

// ===== tb/csbo_bridge_model.sv
// Behavioural host bus bridge facing the backoff sequencer.
module csbo_bridge_model (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Bench commands and the grant from the block.
    input  wire logic want_bus,
    input  wire logic deadlock,
    input  wire logic hold_grant,
    // Requests towards the block.
    output logic      backoff_req,
    output logic      hold_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] use_q;
    // Backoff only on a bench-flagged deadlock; dropped once granted.
    assign backoff_req = deadlock & !hold_grant;
    // The bus is used for three granted cycles, then released.
    assign hold_req = want_bus & (use_q != 2'h3);
    // Count granted cycles; a fresh request starts over.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            use_q <= 2'h0;
        end else if (!want_bus) begin
            use_q <= 2'h0;
        end else if (hold_grant && use_q != 2'h3) begin
            use_q <= use_q + 2'h1;
        end
    end
endmodule : csbo_bridge_model

// ===== tb/cpu_socket_select_and_backoff_bench.sv
// Self-checking bench for the socket select and backoff glue.
module cpu_socket_select_and_backoff_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import csbo_pkg::*;
    logic clk = 0, rst_n = 0, hgr = 0, strap = 1, want = 0, dl = 0, en = 1;
    csbo_bus_t bus = 3'h7;
    logic od_o, od_oe, latch_n, grant, bus_backoff_n_n, breq, hreq;
    int err_total = 0, compares = 0;
    // The pulled-up open-drain pin, low only while driven.
    wire pin = od_oe ? od_o : 1'b1;
    csbo_top dut_u (.REF_CLK(clk), .RESET_N(rst_n), .CLK_EN(en),
        .LOCAL_BUS(bus), .CPU_HOLD_GRANT(hgr),
        .SOCKET_B_EMUL_DISABLE_N(strap), .SOCKET_A_EMUL_DISABLE_N_I(pin),
        .SOCKET_A_EMUL_DISABLE_N_O(od_o), .SOCKET_A_EMUL_DISABLE_N_OE(od_oe),
        .ADDR_LATCH_OUT_EN_N(latch_n), .BRIDGE_BACKOFF_REQUEST(breq),
        .BRIDGE_HOLD_REQUEST(hreq), .BRIDGE_HOLD_GRANT(grant),
        .CPU_BACKOFF_N(bus_backoff_n_n));
    csbo_bridge_model bridge_u (.clk(clk), .rst_n(rst_n), .want_bus(want),
        .deadlock(dl), .hold_grant(grant), .backoff_req(breq),
        .hold_req(hreq));
    // Free-running 200 MHz clock.
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : chk
    task automatic give_verdict;
        $display("Compares %0d, errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    // Closes any open access with ready and burst-last together; the
    // bridge answers each host-bus access once, with no abort pending.
    task automatic end_access;
        @(posedge clk);
        bus <= 3'h4;
        @(posedge clk);
        bus <= 3'h7;
        want <= 0;
        dl <= 0;
    endtask : end_access
    // Every strap and hold grant pairing, checked in the same cycle.
    task automatic t_gates;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            strap <= i[0];
            hgr <= i[1];
            @(negedge clk);
            chk("latch_n", i[0] | i[1], latch_n);
            chk("od_oe", i[0], od_oe);
            chk("od_o", 1'b0, od_o);
            chk("pin", !i[0], pin);
        end
        @(posedge clk);
        strap <= 1;
        hgr <= 0;
        repeat (3) @(posedge clk);
    endtask : t_gates
    // Full backoff, hold grant a cycle later, held past request drop.
    task automatic t_backoff;
        @(posedge clk);
        bus <= 3'h3;
        want <= 1;
        dl <= 1;
        @(posedge clk);
        bus <= 3'h7;
        @(negedge clk);
        chk("bus_backoff_n_n", 1'b0, bus_backoff_n_n);
        chk("grant", 1'b0, grant);
        @(negedge clk);
        chk("grant", 1'b1, grant);
        chk("breq", 1'b0, breq);
        chk("bus_backoff_n_n", 1'b0, bus_backoff_n_n);
        for (int k = 0; k < 10 && hreq !== 1'b0; k++) @(negedge clk);
        chk("bus_backoff_n_n", 1'b0, bus_backoff_n_n);
        @(negedge clk);
        chk("bus_backoff_n_n", 1'b1, bus_backoff_n_n);
        chk("grant", 1'b0, grant);
        end_access();
    endtask : t_backoff
    // A qualifier missing: backoff must never start.
    task automatic t_refuse(input logic s, input logic w, input logic a);
        @(posedge clk);
        strap <= s;
        repeat (3) @(posedge clk);
        bus <= {a, 2'h3};
        want <= w;
        dl <= 1;
        @(posedge clk);
        bus <= 3'h7;
        repeat (4) begin
            @(negedge clk);
            chk("bus_backoff_n_n", 1'b1, bus_backoff_n_n);
            chk("grant", 1'b0, grant);
        end
        end_access();
        strap <= 1;
        repeat (3) @(posedge clk);
    endtask : t_refuse
    // Reset in mid-backoff idles both sequencer outputs at once.
    task automatic t_reset;
        @(posedge clk);
        bus <= 3'h3;
        want <= 1;
        dl <= 1;
        repeat (3) @(posedge clk);
        rst_n <= 0;
        bus <= 3'h7;
        want <= 0;
        dl <= 0;
        @(negedge clk);
        chk("bus_backoff_n_n", 1'b1, bus_backoff_n_n);
        chk("grant", 1'b0, grant);
        @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
    endtask : t_reset
    // A low clock enable freezes the sequencer in mid-grant, even with the
    // hold request gone; the release only follows once it is high again.
    task automatic t_freeze;
        @(posedge clk);
        bus <= 3'h3;
        want <= 1;
        dl <= 1;
        @(posedge clk);
        bus <= 3'h7;
        @(posedge clk);
        en <= 0;
        want <= 0;
        repeat (3) begin
            @(negedge clk);
            chk("bus_backoff_n_n", 1'b0, bus_backoff_n_n);
            chk("grant", 1'b1, grant);
        end
        @(posedge clk);
        en <= 1;
        @(negedge clk);
        chk("bus_backoff_n_n", 1'b0, bus_backoff_n_n);
        @(negedge clk);
        chk("bus_backoff_n_n", 1'b1, bus_backoff_n_n);
        chk("grant", 1'b0, grant);
        end_access();
    endtask : t_freeze
    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        chk("bus_backoff_n_n", 1'b1, bus_backoff_n_n);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        t_gates();
        t_backoff();
        t_refuse(1, 1, 1);
        t_refuse(0, 1, 0);
        t_refuse(1, 0, 0);
        t_reset();
        t_backoff();
        t_freeze();
        give_verdict();
    end
    // Watchdog against a hung sequence.
    initial begin
        repeat (2000) @(posedge clk);
        err_total++;
        give_verdict();
    end
endmodule : cpu_socket_select_and_backoff_bench
